// *** isrp_master_model.sv ***
// two-wire bus master model: makes the clock and pulls the data line low
`timescale 1ns/1ns
// ==========================================================
// master model
module isrp_master_model (
    // clock
    input  wire logic clk_i,
    // bus
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    // phases kept long for the slave's pin synchroniser latency
    localparam int T_Q = 40;
    localparam int T_H = 50;

    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end

    // also serves as repeated start when the clock is low
    task automatic start_cond;
        @(negedge clk_i);
        if (scl_o === 1'b0) begin
            #T_Q sda_oe_o = 1'b0;
            #T_Q scl_o = 1'b1;
        end
        #T_Q sda_oe_o = 1'b1;
        #T_Q scl_o = 1'b0;
    endtask : start_cond

    task automatic stop_cond;
        @(negedge clk_i);
        #T_Q sda_oe_o = 1'b1;
        #T_Q scl_o = 1'b1;
        #T_Q sda_oe_o = 1'b0;
        #T_Q;
    endtask : stop_cond

    task automatic put_bit(input logic b);
        #T_Q sda_oe_o = ~b;
        #T_Q scl_o = 1'b1;
        #T_H scl_o = 1'b0;
    endtask : put_bit

    task automatic get_bit(output logic b);
        #T_Q sda_oe_o = 1'b0;
        #T_Q scl_o = 1'b1;
        #20 b = sda_i;
        #30 scl_o = 1'b0;
    endtask : get_bit

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        @(negedge clk_i);
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(ack);
    endtask : wr_byte

    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic b;
        @(negedge clk_i);
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            d[i] = b;
        end
        put_bit(nack);
    endtask : rd_byte

endmodule : isrp_master_model

// *** isrp_pkg.sv ***
// constants and types shared by the two-wire slave register port
package isrp_pkg;

    // ==========================================================
    // widths
    localparam int REG_AW = 7;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int SYNC_W = 5;

    // ==========================================================
    // bus address and framing
    localparam logic [4:0] ADDR_FIXED = 5'h16;
    localparam logic [3:0] BIT_LAST   = 4'h8;
    localparam logic [1:0] TX_IDX_HI  = 2'h0;
    localparam logic [1:0] TX_IDX_LO  = 2'h1;
    localparam logic [1:0] TX_IDX_END = 2'h2;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;

    // ==========================================================
    // synchroniser slots and reset levels
    localparam int SL_SCL = 0;
    localparam int SL_SDA = 1;
    localparam int SL_AS0 = 2;
    localparam int SL_CLR = 4;
    localparam logic [SYNC_W-1:0] SYNC_RST = 5'h03;

    // ==========================================================
    // channel-six code registers
    localparam logic [REG_AW-1:0] REG_CH6_SRC = 7'h16;
    localparam logic [REG_AW-1:0] REG_CH6_SNK = 7'h1a;
    localparam logic [REG_AW-1:0] REG_CH6_SHT = 7'h1b;

    // ==========================================================
    // state machines
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b010,
        ST_TX   = 3'b011,
        ST_RACK = 3'b100
    } isrp_state_t;

    typedef enum logic [1:0] {
        K_ADDR = 2'b00,
        K_CMD  = 2'b01,
        K_DHI  = 2'b10,
        K_DLO  = 2'b11
    } isrp_kind_t;

endpackage : isrp_pkg

// *** isrp_slave.sv ***
// two-wire bus slave with register write and readback ports
`timescale 1ns/1ns
module isrp_slave (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // two-wire bus pins
    input  wire logic                          scl_i,
    input  wire logic                          sda_i,
    output logic                               sda_o,
    output logic                               sda_oe_o,
    // address select pins
    input  wire logic [1:0]                    addr_sel_i,
    // clear controls
    input  wire logic                          external_clear_input_i,
    input  wire logic                          software_clear_bit_i,
    input  wire logic                          ch6_reset_mode_i,
    // register write port
    output logic                               wr_stb_o,
    output logic      [isrp_pkg::REG_AW-1:0]   wr_addr_o,
    output logic      [isrp_pkg::DATA_W-1:0]   wr_data_o,
    // readback port
    output logic      [isrp_pkg::REG_AW-1:0]   rd_addr_o,
    input  wire logic [isrp_pkg::DATA_W-1:0]   rd_data_i,
    output logic                               busy_o
);
    import isrp_pkg::*;

    // ==========================================================
    // pin synchronisers and edge detection
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_syn;
    logic              scl_s;
    logic              sda_s;
    logic [1:0]        asel_s;
    logic              clr_s;
    logic              scl_q;
    logic              sda_q;

    assign pin_raw = {external_clear_input_i, addr_sel_i, sda_i, scl_i};

    isrp_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pin_raw),
        .q_o   (pin_syn)
    );

    assign scl_s  = pin_syn[SL_SCL];
    assign sda_s  = pin_syn[SL_SDA];
    assign asel_s = pin_syn[SL_AS0+1:SL_AS0];
    assign clr_s  = pin_syn[SL_CLR];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

    // ==========================================================
    // byte framing state
    isrp_state_t       state_q;
    isrp_kind_t        kind_q;
    logic [3:0]        bit_cnt_q;
    logic [BYTE_W-1:0] sr_q;
    logic              rw_q;
    logic [REG_AW-1:0] cmd_q;
    logic [BYTE_W-1:0] hold_q;
    logic [BYTE_W-1:0] tx_sr_q;
    logic [1:0]        tx_idx_q;

    logic byte_done;
    logic addr_match;
    logic ack_ok;
    logic ack_end;
    logic tx_last;
    logic tx_load;
    logic tx_shift;
    logic [BYTE_W-1:0] tx_next;

    assign byte_done  = (state_q == ST_RX) && scl_fall && (bit_cnt_q == BIT_LAST);
    assign addr_match = (sr_q[7:1] == {ADDR_FIXED, asel_s});
    assign ack_ok     = (kind_q != K_ADDR) || addr_match;
    assign ack_end    = (state_q == ST_ACK) && scl_fall;
    assign tx_last    = (state_q == ST_TX) && scl_fall && (bit_cnt_q == BIT_LAST);
    assign tx_load    = (ack_end && (kind_q == K_ADDR)) || ((state_q == ST_RACK) && scl_fall);
    assign tx_shift   = (state_q == ST_TX) && scl_fall && (bit_cnt_q != BIT_LAST);

    // bytes past the second read as zero
    always_comb begin
        unique case (tx_idx_q)
            TX_IDX_HI: tx_next = rd_data_i[DATA_W-1:BYTE_W];
            TX_IDX_LO: tx_next = rd_data_i[BYTE_W-1:0];
            default:   tx_next = BYTE_ZERO;
        endcase
    end

    // start and stop win over any bit position
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            kind_q  <= K_ADDR;
        end else if (start_det) begin
            state_q <= ST_RX;
            kind_q  <= K_ADDR;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                ST_RX: begin
                    if (byte_done) begin
                        state_q <= ack_ok ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        unique case (kind_q)
                            K_ADDR: begin
                                state_q <= rw_q ? ST_TX : ST_RX;
                                kind_q  <= K_CMD;
                            end
                            K_CMD: begin
                                state_q <= ST_RX;
                                kind_q  <= K_DHI;
                            end
                            K_DHI: begin
                                state_q <= ST_RX;
                                kind_q  <= K_DLO;
                            end
                            K_DLO: begin
                                state_q <= ST_RX;
                                kind_q  <= K_CMD;
                            end
                        endcase
                    end
                end
                ST_TX: begin
                    if (tx_last) begin
                        state_q <= ST_RACK;
                    end
                end
                ST_RACK: begin
                    // a not-acknowledge from the master ends our driving
                    if (scl_rise && sda_s) begin
                        state_q <= ST_IDLE;
                    end else if (scl_fall) begin
                        state_q <= ST_TX;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // bit counter: counts rising clock edges within one byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_q <= '0;
        end else if (start_det || byte_done || tx_last || tx_load) begin
            bit_cnt_q <= '0;
        end else if (scl_rise && ((state_q == ST_RX) || (state_q == ST_TX))) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // receive shifter samples on rising clock
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sr_q <= '0;
        end else if (scl_rise && (state_q == ST_RX) && (bit_cnt_q != BIT_LAST)) begin
            sr_q <= {sr_q[BYTE_W-2:0], sda_s};
        end
    end

    // captured fields of the address, command and first data bytes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rw_q      <= 1'b0;
            cmd_q     <= '0;
            hold_q    <= '0;
            rd_addr_o <= '0;
        end else if (byte_done) begin
            unique case (kind_q)
                K_ADDR: rw_q <= sr_q[0];
                K_CMD: begin
                    cmd_q     <= sr_q[BYTE_W-1:1];
                    rd_addr_o <= sr_q[BYTE_W-1:1];
                end
                K_DHI: hold_q <= sr_q;
                K_DLO: hold_q <= hold_q;
            endcase
        end
    end

    // ==========================================================
    // commit of staged data
    logic ch6_code;
    logic ch6_blocked;

    assign ch6_code = (cmd_q == REG_CH6_SRC) || (cmd_q == REG_CH6_SNK) ||
                      (cmd_q == REG_CH6_SHT);
    // clear only gates this commit; framing never looks at it
    assign ch6_blocked = ch6_code && ch6_reset_mode_i &&
                         (clr_s || software_clear_bit_i);

    // commit lands in the acknowledge clock of the second data byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_stb_o  <= 1'b0;
            wr_addr_o <= '0;
            wr_data_o <= '0;
        end else begin
            wr_stb_o <= byte_done && (kind_q == K_DLO) && !ch6_blocked;
            if (byte_done && (kind_q == K_DLO)) begin
                wr_addr_o <= cmd_q;
                wr_data_o <= {hold_q, sr_q};
            end
        end
    end

    // ==========================================================
    // readback shifter and byte index
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sr_q  <= '0;
            tx_idx_q <= TX_IDX_HI;
        end else if (start_det) begin
            tx_idx_q <= TX_IDX_HI;
        end else if (tx_load) begin
            tx_sr_q <= tx_next;
            if (tx_idx_q != TX_IDX_END) begin
                tx_idx_q <= tx_idx_q + 2'h1;
            end
        end else if (tx_shift) begin
            tx_sr_q <= {tx_sr_q[BYTE_W-2:0], 1'b0};
        end
    end

    // ==========================================================
    // open-drain data driver, changed on falling clock or released at start and stop
    assign sda_o = 1'b0;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_oe_o <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_o <= 1'b0;
        end else if (byte_done) begin
            sda_oe_o <= ack_ok;
        end else if (tx_load && rw_q) begin
            sda_oe_o <= ~tx_next[BYTE_W-1];
        end else if (tx_shift) begin
            sda_oe_o <= ~tx_sr_q[BYTE_W-2];
        end else if (ack_end || tx_last || ((state_q == ST_RACK) && scl_fall)) begin
            sda_oe_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_q != ST_IDLE);
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_dlo_done;
        byte_done && (kind_q == K_DLO) && !ch6_blocked;
    endsequence

    sequence s_stb_in_ack;
        wr_stb_o && (state_q == ST_ACK) && (kind_q == K_DLO);
    endsequence

    a_commit_ack_slot: assert property (s_dlo_done |=> s_stb_in_ack)
        else $error("commit missed the acknowledge slot");
    a_ch6_blocked: assert property (byte_done && ch6_blocked |=> !wr_stb_o)
        else $error("channel-six write passed while held in reset");
    a_stb_single: assert property (wr_stb_o |=> !wr_stb_o)
        else $error("commit strobe longer than one cycle");
    a_stop_idle: assert property (stop_det && !start_det |=> state_q == ST_IDLE)
        else $error("stop did not end the transfer");
    a_start_addr: assert property (start_det |=> (state_q == ST_RX) && (kind_q == K_ADDR)
                                   && (bit_cnt_q == 4'h0))
        else $error("start did not arm address reception");
    a_nomatch_quiet: assert property (byte_done && (kind_q == K_ADDR) && !addr_match
                                      |=> !sda_oe_o && (state_q == ST_IDLE))
        else $error("foreign address acknowledged");
    a_ack_pull: assert property (byte_done && ack_ok && !start_det && !stop_det
                                 |=> sda_oe_o)
        else $error("acknowledge not driven");
    a_oe_clk_low: assert property ($changed(sda_oe_o) && !$past(start_det) && !$past(stop_det)
                                   |-> !scl_q)
        else $error("data driver moved while clock high");
    a_extra_zero: assert property (tx_load && rw_q && (tx_idx_q == TX_IDX_END)
                                   |=> sda_oe_o)
        else $error("extra readback byte not zero");
    a_cmd_field: assert property (byte_done && (kind_q == K_CMD)
                                  |=> cmd_q == $past(sr_q[BYTE_W-1:1]))
        else $error("register address not from upper seven bits");
    a_restart_idx: assert property (start_det |=> tx_idx_q == TX_IDX_HI)
        else $error("readback did not restart at first byte");

endmodule : isrp_slave

// *** isrp_slave_tb.sv ***
// self-checking bench for the two-wire slave register port
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module isrp_slave_tb;
    import isrp_pkg::*;
    localparam logic [7:0] AW = {ADDR_FIXED, 2'b10, 1'b0};
    localparam logic [7:0] AR = {ADDR_FIXED, 2'b10, 1'b1};
    logic                clk_i, rst_i, ext_clr, software_clear_bit, ch6_rst;
    wire logic           scl, sda, m_oe, sda_o, sda_oe, wr_stb, busy;
    wire logic [6:0]     wr_addr, rd_addr;
    wire logic [15:0]    wr_data, rd_data;
    int                  fails, check_count, stb_cnt;
    logic [6:0]          log_addr [4];
    logic [15:0]         log_data [4];

    // pull-up: any party pulling low wins
    assign sda     = ~(m_oe | sda_oe);
    assign rd_data = {1'b1, rd_addr, 8'h69};

    isrp_master_model mst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    isrp_slave dut (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .addr_sel_i(2'b10), .external_clear_input_i(ext_clr),
        .software_clear_bit_i(software_clear_bit), .ch6_reset_mode_i(ch6_rst), .wr_stb_o(wr_stb),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_addr_o(rd_addr),
        .rd_data_i(rd_data), .busy_o(busy)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (wr_stb === 1'b1) begin
            if (stb_cnt < 4) begin
                log_addr[stb_cnt] = wr_addr;
                log_data[stb_cnt] = wr_data;
            end
            stb_cnt++;
        end
        if (sda_o !== 1'b0) begin
            fails++;
            $display("CHECK FAILED sda_o expected 0 seen %b", sda_o);
        end
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic wait_idle;
        for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk_i);
        @(negedge clk_i);
        if (busy !== 1'b0) begin
            fails++;
            $display("CHECK FAILED busy expected 0 seen %b", busy);
            wrap_up();
        end
    endtask : wait_idle

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic a;
        mst.wr_byte(b, a);
        `CHK("ack", exp_ack, a)
    endtask : send

    // command bit 0 set on purpose: it must be ignored
    task automatic write_one(input logic [6:0] r, input logic [15:0] d);
        mst.start_cond();
        send(AW, 1'b0);
        send({r, 1'b1}, 1'b0);
        send(d[15:8], 1'b0);
        send(d[7:0], 1'b0);
        mst.stop_cond();
        wait_idle();
    endtask : write_one

    task automatic t_write;
        stb_cnt = 0;
        mst.start_cond();
        send(AW, 1'b0);
        send({7'h11, 1'b1}, 1'b0);
        send(8'ha5, 1'b0);
        send(8'h3c, 1'b0);
        send({7'h16, 1'b1}, 1'b0);
        send(8'h01, 1'b0);
        send(8'h02, 1'b0);
        mst.stop_cond();
        wait_idle();
        `CHK("stb count", 2, stb_cnt)
        `CHK("addr 0", 7'h11, log_addr[0])
        `CHK("data 0", 16'ha53c, log_data[0])
        `CHK("addr 1", 7'h16, log_addr[1])
        `CHK("data 1", 16'h0102, log_data[1])
        $display("test write done");
    endtask : t_write

    task automatic t_noack;
        stb_cnt = 0;
        mst.start_cond();
        send({ADDR_FIXED, 2'b01, 1'b0}, 1'b1);
        send({7'h11, 1'b0}, 1'b1);
        mst.stop_cond();
        wait_idle();
        `CHK("stb count", 0, stb_cnt)
        $display("test address mismatch done");
    endtask : t_noack

    task automatic t_abort;
        stb_cnt = 0;
        mst.start_cond();
        send(AW, 1'b0);
        send({7'h12, 1'b0}, 1'b0);
        send(8'h11, 1'b0);
        mst.stop_cond();
        wait_idle();
        `CHK("stb after stop", 0, stb_cnt)
        mst.start_cond();
        send(AW, 1'b0);
        send({7'h12, 1'b0}, 1'b0);
        send(8'h22, 1'b0);
        mst.start_cond();
        send(AW, 1'b0);
        send({7'h13, 1'b0}, 1'b0);
        send(8'h55, 1'b0);
        send(8'h66, 1'b0);
        mst.stop_cond();
        wait_idle();
        `CHK("stb after restart", 1, stb_cnt)
        `CHK("addr", 7'h13, log_addr[0])
        `CHK("data", 16'h5566, log_data[0])
        $display("test abort done");
    endtask : t_abort

    task automatic t_ch6;
        logic [6:0] regs [3];
        regs = '{REG_CH6_SRC, REG_CH6_SNK, REG_CH6_SHT};
        stb_cnt = 0;
        ch6_rst = 1'b1;
        software_clear_bit  = 1'b1;
        for (int i = 0; i < 3; i++) write_one(regs[i], 16'h7777);
        `CHK("stb soft clear", 0, stb_cnt)
        software_clear_bit  = 1'b0;
        ext_clr = 1'b1;
        write_one(REG_CH6_SHT, 16'h1234);
        `CHK("stb pin clear", 0, stb_cnt)
        write_one(7'h11, 16'h0f0f);
        `CHK("stb other channel", 1, stb_cnt)
        ch6_rst = 1'b0;
        write_one(REG_CH6_SRC, 16'h4321);
        `CHK("stb no reset mode", 2, stb_cnt)
        `CHK("data", 16'h4321, log_data[1])
        ext_clr = 1'b0;
        $display("test channel six done");
    endtask : t_ch6

    task automatic t_read;
        logic [7:0] d;
        logic [2:0] b;
        stb_cnt = 0;
        mst.start_cond();
        send(AW, 1'b0);
        send({REG_CH6_SRC, 1'b0}, 1'b0);
        `CHK("rd_addr", REG_CH6_SRC, rd_addr)
        mst.start_cond();
        send(AR, 1'b0);
        mst.rd_byte(1'b0, d);
        `CHK("read hi", {1'b1, REG_CH6_SRC}, d)
        mst.rd_byte(1'b0, d);
        `CHK("read lo", 8'h69, d)
        mst.rd_byte(1'b1, d);
        `CHK("read extra", 8'h00, d)
        mst.stop_cond();
        wait_idle();
        `CHK("stb count", 0, stb_cnt)
        mst.start_cond();
        send(AR, 1'b0);
        mst.get_bit(b[2]);
        mst.get_bit(b[1]);
        mst.get_bit(b[0]);
        `CHK("partial bits", 3'b100, b)
        mst.stop_cond();
        wait_idle();
        mst.start_cond();
        send(AR, 1'b0);
        mst.rd_byte(1'b1, d);
        `CHK("read restart", {1'b1, REG_CH6_SRC}, d)
        mst.stop_cond();
        wait_idle();
        $display("test readback done");
    endtask : t_read

    initial begin
        fails       = 0;
        check_count = 0;
        stb_cnt     = 0;
        rst_i       = 1'b1;
        ext_clr     = 1'b0;
        software_clear_bit      = 1'b0;
        ch6_rst     = 1'b0;
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        t_write();
        t_noack();
        t_abort();
        t_ch6();
        t_read();
        wrap_up();
    end

    // cuts a hung run short
    initial begin
        #500000;
        fails++;
        $display("CHECK FAILED watchdog expected done seen hang");
        wrap_up();
    end

endmodule : isrp_slave_tb

// *** isrp_sync.sv ***
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module isrp_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // async in, synced out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule : isrp_sync
